// ### src/shift_store_pkg.sv
// Constants and carrier types for the serial shift-and-store block.
// Assumes a single 100 MHz system clock; all pins are sampled into it.
// Functional notes
// - The block holds an eight-stage serial shift chain, an equal storage register and three-state parallel outputs.
// - The shift chain moves only on the shift clock and the storage register only on the transfer strobe.
// - Each rising shift clock edge moves every stage one place on and loads serial data into the first stage.
// - The fast cascade output updates at the rising shift clock edge.
// - The slow cascade output takes the same bit at the following falling shift clock edge.
// - At each rising edge the seventh stage passes into the eighth stage and onto the fast cascade output.
// - At a rising edge the fast cascade output shows what stage seven held just before that edge.
// - At a falling edge the slow cascade output shows what stage eight held just before that edge.
// - While the strobe is high storage follows the shift chain, while low it holds.
// - While output enable is high the parallel outputs drive the storage contents.
// - While output enable is low every parallel output is released.
// - Output enable never alters either register and the cascade outputs keep running while disabled.
package shift_store_pkg;

    // ************************************************************
    // Sizes and reset values
    // ************************************************************
    localparam int          STAGES      = 8;
    localparam int          FIFO_DEPTH  = 16;
    localparam logic [7:0]  STAGE_RST   = 8'h00;
    localparam logic        BIT_RST     = 1'b0;
    localparam int          FIRST_STAGE = 0;
    localparam int          SIX_IDX     = 5;  // Stage six, counted from one
    localparam int          SEVEN_IDX   = 6;  // Stage seven
    localparam int          EIGHT_IDX   = 7;  // Stage eight

    // Synchronised pin sample
    typedef struct packed {
        logic shift_clock;
        logic serial_in;
        logic transfer_strobe;
        logic output_enable;
    } pins_s;

    // Whole block state
    typedef struct packed {
        pins_s                  meta;
        pins_s                  sync;
        logic                   clk_prev;
        logic [STAGES-1:0]      stage;
        logic [STAGES-1:0]      store;
        logic                   cascade_out_fast;
        logic                   cascade_out_slow;
        logic [STAGES-1:0]      parallel_out;
        logic [STAGES-1:0]      parallel_oe;
        logic                   strobe_prev;
        logic                   word_drop;
        logic                   word_valid;
        logic [STAGES-1:0]      word_data;
    } state_s;

endpackage

// ### src/shift_store_fifo.sv
// Word FIFO with valid/ready on both sides.
// Assumes one clock; a write and a read may fall in the same cycle.
module shift_store_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } fifo_s;

    logic [WIDTH-1:0] mem [DEPTH];
    fifo_s            st_r;
    fifo_s            st_nxt;
    logic             push;
    logic             pop;

    // Handshakes; full and empty come straight from the count
    assign o_in_ready  = (st_r.count != (AW+1)'(DEPTH));
    assign o_out_valid = (st_r.count != '0);
    assign o_out_data  = mem[st_r.rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // Pointer and count update
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
        end
        st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Storage has no reset; only the pointers and count need one
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[st_r.wr_ptr] <= i_in_data;
        end
    end

endmodule

// ### src/serial_shift_store_register.sv
// Serial-in shift chain with storage register and three-state parallel outputs.
// Pins arrive asynchronously; shift clock edges are found by oversampling at 100 MHz,
// so the shift clock must stay high and low for at least three system cycles each.
module serial_shift_store_register (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_shift_clock,
    input  wire logic       i_serial_in,
    input  wire logic       i_transfer_strobe,
    input  wire logic       i_output_enable,
    input  wire logic       i_word_ready,
    output logic      [7:0] o_parallel_out,
    output logic      [7:0] o_parallel_oe,
    output logic            o_cascade_out_fast,
    output logic            o_cascade_out_slow,
    output logic            o_word_valid,
    output logic      [7:0] o_word_data,
    output logic            o_word_drop
);
    shift_store_pkg::state_s st_r;
    shift_store_pkg::state_s st_nxt;
    logic                    rise;
    logic                    fall;
    logic                    fifo_ready;
    logic                    word_push;
    logic                    out_valid;
    logic [7:0]              out_data;

    // ************************************************************
    // Edge detection on the synchronised shift clock
    // ************************************************************
    // Only the second sync stage is looked at, never the first
    assign rise = st_r.sync.shift_clock && !st_r.clk_prev;
    assign fall = !st_r.sync.shift_clock && st_r.clk_prev;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.meta      = '{i_shift_clock, i_serial_in, i_transfer_strobe, i_output_enable};
        st_nxt.sync      = st_r.meta;
        st_nxt.clk_prev  = st_r.sync.shift_clock;
        // Shift chain moves only on the shift clock rise
        if (rise)
        begin
            st_nxt.stage = {st_r.stage[shift_store_pkg::SEVEN_IDX:0],
                            st_r.sync.serial_in};
            st_nxt.cascade_out_fast = st_r.stage[shift_store_pkg::SEVEN_IDX];
        end
        // Slow cascade copies the last stage half a clock later
        if (fall)
        begin
            st_nxt.cascade_out_slow = st_r.stage[shift_store_pkg::EIGHT_IDX];
        end
        // Transparent storage while strobe is high; tracks the newly shifted value too
        if (st_r.sync.transfer_strobe)
        begin
            st_nxt.store = st_nxt.stage;
        end
        // Enable only gates the pins, never the registers
        st_nxt.parallel_out = st_nxt.store;
        st_nxt.parallel_oe  = {shift_store_pkg::STAGES{st_r.sync.output_enable}};
        // Remember the strobe so that only its rise queues a word
        st_nxt.strobe_prev  = st_r.sync.transfer_strobe;
        // A full FIFO loses the word; the pins are never held up for it
        st_nxt.word_drop    = word_push && !fifo_ready;
        // Output slot: drain on ready, refill only while the consumer is ready
        if (st_r.word_valid)
        begin
            st_nxt.word_valid = !i_word_ready;
        end
        else if (out_valid && i_word_ready)
        begin
            st_nxt.word_valid = 1'b1;
            st_nxt.word_data  = out_data;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Word stream: each strobe rise queues the shift chain byte
    // ************************************************************
    // A full FIFO drops the word and flags it; the pins are never stalled
    assign word_push = st_r.sync.transfer_strobe && !st_r.strobe_prev;

    shift_store_fifo #(
        .WIDTH (shift_store_pkg::STAGES),
        .DEPTH (shift_store_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (word_push),
        .o_in_ready  (fifo_ready),
        .i_in_data   (st_r.stage),
        .o_out_valid (out_valid),
        .i_out_ready (i_word_ready && !o_word_valid),
        .o_out_data  (out_data)
    );

    // Every output is a field of the state register
    assign o_parallel_out     = st_r.parallel_out;
    assign o_parallel_oe      = st_r.parallel_oe;
    assign o_cascade_out_fast = st_r.cascade_out_fast;
    assign o_cascade_out_slow = st_r.cascade_out_slow;
    assign o_word_drop        = st_r.word_drop;
    assign o_word_valid       = st_r.word_valid;
    assign o_word_data        = st_r.word_data;

    // ************************************************************
    // Checks
    // ************************************************************
    // Shift side: the first stage, every later stage and both cascades
    AST_SHIFT_IN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rise |=> st_r.stage[shift_store_pkg::FIRST_STAGE] == $past(st_r.sync.serial_in))
        else $error("first stage did not load serial data");

    // One check per stage after the first; a stage that skips or repeats a bit trips here
    for (genvar g = shift_store_pkg::FIRST_STAGE + 1; g < shift_store_pkg::STAGES; g++)
    begin : g_stage_chk
        AST_STAGE_MOVE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            rise |=> st_r.stage[g] == $past(st_r.stage[g-1]))
            else $error("shift stage did not take its neighbour");
    end

    AST_LAST_STAGE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rise |=> st_r.stage[shift_store_pkg::EIGHT_IDX] == o_cascade_out_fast)
        else $error("last stage and fast cascade disagree after rise");

    AST_FAST: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rise |=> o_cascade_out_fast == $past(st_r.stage[shift_store_pkg::SEVEN_IDX]))
        else $error("fast cascade wrong after rise");

    AST_FAST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !rise |=> $stable(o_cascade_out_fast))
        else $error("fast cascade moved without rise");

    AST_SLOW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        fall |=> o_cascade_out_slow == $past(st_r.stage[shift_store_pkg::EIGHT_IDX]))
        else $error("slow cascade wrong after fall");

    // The slow copy may only move at a fall, never at a rise
    AST_SLOW_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !fall |=> $stable(o_cascade_out_slow))
        else $error("slow cascade moved without fall");

    AST_CHAIN_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !rise |=> $stable(st_r.stage))
        else $error("shift chain moved without rise");

    // Cascading must keep working with the parallel pins released
    AST_CASCADE_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !st_r.sync.output_enable && rise
            |=> o_cascade_out_fast == $past(st_r.stage[shift_store_pkg::SEVEN_IDX]))
        else $error("fast cascade stalled while disabled");

    AST_OE_REGS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $changed(st_r.sync.output_enable) && !rise && !st_r.sync.transfer_strobe
            |=> $stable(st_r.stage) && $stable(st_r.store))
        else $error("enable change disturbed a register");

    // Storage side
    AST_STORE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !st_r.sync.transfer_strobe |=> $stable(st_r.store))
        else $error("storage changed with strobe low");

    AST_STORE_FOLLOW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        st_r.sync.transfer_strobe |=> st_r.store == st_r.stage)
        else $error("storage not transparent with strobe high");

    AST_PAR_OUT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        st_r.sync.transfer_strobe && !rise |=> o_parallel_out == $past(st_r.stage))
        else $error("outputs do not show storage");

    AST_OE_ON: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        st_r.sync.output_enable |=> o_parallel_oe == '1)
        else $error("outputs not driven while enabled");

    AST_OE_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !st_r.sync.output_enable |=> o_parallel_oe == '0)
        else $error("outputs driven while disabled");

    // A fall may only let a transparent store catch up, never shift it
    AST_FALL_PAR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        fall |=> $stable(o_parallel_out) || o_parallel_out == $past(st_r.stage))
        else $error("falling edge changed parallel outputs");

    // Word stream: a held word stays put, a lost word is always flagged
    AST_WORD_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word_data))
        else $error("word changed before it was taken");

    AST_DROP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        word_push && !fifo_ready |=> o_word_drop)
        else $error("full queue lost a word silently");

    AST_NO_DROP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !(word_push && !fifo_ready) |=> !o_word_drop)
        else $error("drop flagged without a lost word");

endmodule

// ### dv/host_model.sv
// Host controller model driving shift clock, serial data, strobe and enable pins.
// Assumes the bench calls its tasks just after a rising system clock edge.
module host_model (
    input  wire logic i_clk,
    output logic      o_shift_clock,
    output logic      o_serial_in,
    output logic      o_transfer_strobe,
    output logic      o_output_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Pin sequencing
    // ************************************************************
    // Idle pins at time zero, parallel drive enabled
    initial
    begin
        o_shift_clock     = 1'b0;
        o_serial_in       = 1'b0;
        o_transfer_strobe = 1'b0;
        o_output_enable   = 1'b1;
    end

    // Data settles six cycles ahead of the rise, twice what the synchroniser needs
    task automatic rise_bit(input logic b);
        o_serial_in <= b;
        repeat (6) @(posedge i_clk);
        o_shift_clock <= 1'b1;
        repeat (6) @(posedge i_clk);
    endtask

    // Hold time is over at the fall, so the data line turns to the inverse
    task automatic fall_bit();
        o_shift_clock <= 1'b0;
        o_serial_in   <= ~o_serial_in;
        repeat (6) @(posedge i_clk);
    endtask

    // Called once a whole byte has been shifted in, and after every single bit in the FIFO test
    task automatic strobe();
        o_transfer_strobe <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_transfer_strobe <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask

    // Level control of the strobe, for transparent storage while shifting
    task automatic set_strobe(input logic s);
        o_transfer_strobe <= s;
        repeat (6) @(posedge i_clk);
    endtask

    task automatic set_enable(input logic en);
        o_output_enable <= en;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

// ### dv/serial_shift_store_register_bench.sv
// Self-checking bench for the serial shift-and-store block and its word FIFO.
// Assumes host_model drives the pins; the bench owns clock, reset and word ready.
module serial_shift_store_register_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk        = 1'b0;
    logic       rst_b      = 1'b0;
    logic       word_ready = 1'b1;
    logic       sclk, sin, stb, oe, fast, slow, wvalid, wdrop;
    logic [7:0] par, par_oe, wdata;
    logic [7:0] chain_m    = 8'h00;
    logic [7:0] words_m[$];
    int         mismatches = 0;
    int         total_checks = 0;
    int         drops      = 0;
    int         cycles     = 0;

    // ************************************************************
    // Clock, watchdog and instances
    // ************************************************************
    always #5 clk = ~clk;

    // Ceiling sits well above the roughly 1100 cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (wdrop === 1'b1)
            drops++;
        if (cycles == 8000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    host_model i_host (.i_clk(clk), .o_shift_clock(sclk), .o_serial_in(sin),
                       .o_transfer_strobe(stb), .o_output_enable(oe));

    serial_shift_store_register i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_shift_clock(sclk),
        .i_serial_in(sin), .i_transfer_strobe(stb), .i_output_enable(oe),
        .i_word_ready(word_ready), .o_parallel_out(par), .o_parallel_oe(par_oe),
        .o_cascade_out_fast(fast), .o_cascade_out_slow(slow), .o_word_valid(wvalid),
        .o_word_data(wdata), .o_word_drop(wdrop));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // One shift; cascade outputs judged after the rise and after the fall
    task automatic shift_bit(input logic b);
        logic       old8;
        logic [7:0] par0;
        old8    = chain_m[7];
        par0    = par;
        chain_m = {chain_m[6:0], b};
        i_host.rise_bit(b);
        check("fast", 8'(fast), 8'(chain_m[7]));
        check("slow early", 8'(slow), 8'(old8));
        i_host.fall_bit();
        check("slow", 8'(slow), 8'(chain_m[7]));
        check("fast at fall", 8'(fast), 8'(chain_m[7]));
        check("parallel at fall", par, par0);
    endtask

    // First bit sent ends in the top stage
    task automatic shift_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--)
            shift_bit(v[i]);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_load();
        shift_byte(8'hA5);
        check("held store", par, 8'h00);
        i_host.strobe();
        check("stored", par, 8'hA5);
        check("enable", par_oe, 8'hFF);
    endtask

    // Cascade keeps running while disabled; storage survives enable changes
    task automatic t_oe();
        i_host.set_enable(1'b0);
        check("disabled", par_oe, 8'h00);
        shift_byte(8'h3C);
        i_host.set_enable(1'b1);
        check("kept store", par, 8'hA5);
        i_host.strobe();
        check("new store", par, 8'h3C);
    endtask

    // Strobe held high: storage is transparent and follows every shift
    task automatic t_transparent();
        i_host.set_strobe(1'b1);
        check("transparent", par, chain_m);
        chain_m = {chain_m[6:0], 1'b1};
        i_host.rise_bit(1'b1);
        check("follow rise", par, chain_m);
        check("fast follow", 8'(fast), 8'(chain_m[7]));
        i_host.fall_bit();
        check("follow fall", par, chain_m);
        check("slow follow", 8'(slow), 8'(chain_m[7]));
        i_host.set_strobe(1'b0);
    endtask

    // Fill past sixteen words with the consumer stalled, then drain
    task automatic t_fifo();
        int taken;
        taken = 0;
        word_ready <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 17; i++)
        begin
            shift_bit(i[0]);
            if (i < 16)
                words_m.push_back(chain_m);
            i_host.strobe();
        end
        check("drops", 8'(drops), 8'h01);
        word_ready <= 1'b1;
        for (int k = 0; k < 200; k++)
        begin
            @(posedge clk);
            if (wvalid === 1'b1 && word_ready === 1'b1 && words_m.size() > 0)
            begin
                check("word", wdata, words_m.pop_front());
                taken++;
            end
        end
        check("words", 8'(taken), 8'h10);
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_load();
        t_oe();
        t_transparent();
        t_fifo();
        give_verdict();
    end
endmodule
